// ### inc/dmic_pkg.sv
/*
  shared constants and command type for the ddr memory io capture link.
  assumes both ends are built from the same package values.
*/
package dmic_pkg;
  localparam int DQ_W        = 36;
  localparam int GRP_W       = 9;
  localparam int STROBES     = 4;
  localparam int BANKS       = 16;
  localparam int BANK_W      = 4;
  localparam int ADDR_W      = 4;
  localparam int ROW_W       = 8;
  localparam int MAX_BEATS   = 8;
  // link cycles from the command edge to the strobe edge carrying beat 0
  localparam int WRITE_LAT   = 1;
  // link cycles from the command edge to the first driven read pair
  localparam int READ_LAT    = 4;
  // clk_in cycles the host idles after a write burst
  localparam int HOST_GAP    = 8;
  localparam int RD_TIMEOUT  = 63;
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_DLL_BIT = 2;
  localparam logic [1:0] BL_CODE_2 = 2'h0;
  localparam logic [1:0] BL_CODE_4 = 2'h1;
  localparam logic [1:0] BL_CODE_8 = 2'h2;
  localparam logic [3:0] BEATS_2   = 4'h2;
  localparam logic [3:0] BEATS_4   = 4'h4;
  localparam logic [3:0] BEATS_8   = 4'h8;
  localparam logic [3:0] BEATS_RST = 4'h2;
  localparam logic       DLL_RST   = 1'b0;

  typedef enum logic [2:0] {
    DMIC_NOP     = 3'h0,
    DMIC_READ    = 3'h1,
    DMIC_WRITE   = 3'h2,
    DMIC_REFRESH = 3'h3,
    DMIC_MODE    = 3'h4
  } dmic_cmd_t;
endpackage

// ### inc/dmic_link_if.sv
/*
  link between the memory device end and the host controller end.
  assumes the host drives command_clock and write_data_strobe.
*/
`timescale 1ns/100ps
interface dmic_link_if #(
  parameter int ADDR_W = dmic_pkg::ADDR_W
);
  logic                            command_clock;
  logic                            write_data_strobe;
  dmic_pkg::dmic_cmd_t             cmd;
  logic [dmic_pkg::BANK_W-1:0]     bank;
  logic [ADDR_W-1:0]               addr;
  logic [dmic_pkg::DQ_W-1:0]       host_dq;
  logic                            host_dq_oe;
  logic [dmic_pkg::DQ_W-1:0]       dev_dq;
  logic                            dev_dq_oe;
  logic [dmic_pkg::DQ_W-1:0]       dq;
  logic [dmic_pkg::STROBES-1:0]    read_data_strobe;
  logic [dmic_pkg::STROBES-1:0]    read_data_strobe_n;
  logic                            read_valid;

  // resolved data wire; an undriven bus reads as zero
  assign dq = dev_dq_oe ? dev_dq : (host_dq_oe ? host_dq : '0);

  modport device (
    input  command_clock, write_data_strobe, cmd, bank, addr, dq,
    output dev_dq, dev_dq_oe, read_data_strobe, read_data_strobe_n, read_valid
  );
  modport host (
    output command_clock, write_data_strobe, cmd, bank, addr, host_dq, host_dq_oe,
    input  dq, read_data_strobe, read_valid
  );
endinterface

// ### core/dmic_device.sv
/*
  memory device end: command capture, ddr write capture, burst engine,
  flip-flop array in sixteen banks, per bank refresh rows, ddr read launch.
  assumes command_clock and write_data_strobe come from the host as one
  free-running, phase-locked pair, and that rst_in is held while they run.
*/
// Behaviour
// - commands sampled on command clock rising edge
// - write data taken on both strobe edges
// - two data bits per cycle per line
// - read data launched against read strobes
// - bursts of 2, 4 or 8 via mode
// - sixteen banks chosen by bank inputs
// - per bank refresh, row generated internally
// - four read strobe pairs, nine lines each
// - pair 0 and pair 1 line mapping
// - host may capture with pairs 0, 1 only
// - host keeps the delay loop enabled
// - host avoids undefined commands
`timescale 1ns/100ps
module dmic_device #(
  parameter int ADDR_W = dmic_pkg::ADDR_W,
  parameter int ROW_W  = dmic_pkg::ROW_W
) (
  dmic_link_if.device                 link,
  input  wire logic                   rst_in,
  output logic [3:0]                  burst_beats_out,
  output logic                        dll_on_out,
  output logic [dmic_pkg::BANK_W-1:0] refresh_bank_out,
  output logic [ROW_W-1:0]            refresh_row_out
);
  localparam int DQ_W   = dmic_pkg::DQ_W;
  localparam int GRP_W  = dmic_pkg::GRP_W;
  localparam int BANK_W = dmic_pkg::BANK_W;
  localparam int BANKS  = dmic_pkg::BANKS;
  localparam int DEPTH  = BANKS * (2 ** ADDR_W);
  localparam int IDX_W  = BANK_W + ADDR_W;
  localparam logic [2:0] WR_WAIT = 3'(dmic_pkg::WRITE_LAT);
  // three edges of the read latency are spent in the capture pipeline
  localparam logic [2:0] RD_WAIT = 3'(dmic_pkg::READ_LAT - 3);

  typedef enum logic [1:0] {
    DEV_IDLE = 2'h0,
    DEV_WR   = 2'h1,
    DEV_RD   = 2'h2
  } dmic_dev_state_t;

  logic                      clk;
  logic [1:0]                rst_sync_reg;
  logic                      rst;
  dmic_pkg::dmic_cmd_t       cmd_s1_reg;
  dmic_pkg::dmic_cmd_t       cmd_s2_reg;
  logic [BANK_W-1:0]         bank_s1_reg;
  logic [BANK_W-1:0]         bank_s2_reg;
  logic [ADDR_W-1:0]         addr_s1_reg;
  logic [ADDR_W-1:0]         addr_s2_reg;
  logic [DQ_W-1:0]           wr_rise_reg;
  logic [DQ_W-1:0]           wr_fall_reg;
  logic [2*DQ_W-1:0]         wpair_s1_reg;
  logic [2*DQ_W-1:0]         wpair_s2_reg;
  logic [DQ_W-1:0]           mem_reg [DEPTH];
  dmic_dev_state_t           state_reg;
  dmic_dev_state_t           state_next;
  logic [2:0]                wait_reg;
  logic [2:0]                wait_next;
  logic [2:0]                left_reg;
  logic [2:0]                left_next;
  logic [BANK_W-1:0]         bank_reg;
  logic [BANK_W-1:0]         bank_next;
  logic [ADDR_W-1:0]         col_reg;
  logic [ADDR_W-1:0]         col_next;
  logic [3:0]                beats_reg;
  logic [3:0]                beats_next;
  logic                      dll_reg;
  logic                      dll_next;
  logic [DQ_W-1:0]           rd_rise_reg;
  logic [DQ_W-1:0]           rd_rise_next;
  logic [DQ_W-1:0]           rd_fall_reg;
  logic [DQ_W-1:0]           rd_fall_next;
  logic                      rd_valid_reg;
  logic                      rd_valid_next;
  logic [BANK_W-1:0]         ref_bank_reg;
  logic [BANK_W-1:0]         ref_bank_next;
  logic [ROW_W-1:0]          ref_row_reg;
  logic [ROW_W-1:0]          ref_row_next;
  logic                      ref_en;
  logic                      mem_we;
  logic [IDX_W-1:0]          idx0;
  logic [IDX_W-1:0]          idx1;
  logic [ROW_W-1:0]          row_reg [BANKS];

  assign clk = link.command_clock;
  assign rst = rst_sync_reg[1];

  always_ff @(posedge clk) begin
    rst_sync_reg <= {rst_sync_reg[0], rst_in};
  end

  // two capture stages; the command acts on the second
  always_ff @(posedge clk) begin
    cmd_s1_reg  <= link.cmd;
    bank_s1_reg <= link.bank;
    addr_s1_reg <= link.addr;
    cmd_s2_reg  <= cmd_s1_reg;
    bank_s2_reg <= bank_s1_reg;
    addr_s2_reg <= addr_s1_reg;
  end

  always_ff @(posedge link.write_data_strobe) begin
    wr_rise_reg <= link.dq;
  end

  always_ff @(negedge link.write_data_strobe) begin
    wr_fall_reg <= link.dq;
  end

  // strobe and command clock share one source, so at least half a period of margin
  // (the falling capture) separates the strobe captures from this pair register
  always_ff @(posedge clk) begin
    wpair_s1_reg <= {wr_fall_reg, wr_rise_reg};
    wpair_s2_reg <= wpair_s1_reg;
  end

  always_comb begin
    state_next    = state_reg;
    wait_next     = wait_reg;
    left_next     = left_reg;
    bank_next     = bank_reg;
    col_next      = col_reg;
    beats_next    = beats_reg;
    dll_next      = dll_reg;
    rd_rise_next  = rd_rise_reg;
    rd_fall_next  = rd_fall_reg;
    rd_valid_next = 1'b0;
    ref_bank_next = ref_bank_reg;
    ref_row_next  = ref_row_reg;
    ref_en        = 1'b0;
    mem_we        = 1'b0;
    idx0          = {bank_reg, col_reg};
    idx1          = {bank_reg, col_reg + ADDR_W'(1)};
    if (cmd_s2_reg == dmic_pkg::DMIC_MODE) begin
      case (addr_s2_reg[dmic_pkg::MODE_BL_LSB +: 2])
        dmic_pkg::BL_CODE_2: beats_next = dmic_pkg::BEATS_2;
        dmic_pkg::BL_CODE_4: beats_next = dmic_pkg::BEATS_4;
        dmic_pkg::BL_CODE_8: beats_next = dmic_pkg::BEATS_8;
        default:             beats_next = beats_reg;
      endcase
      dll_next = addr_s2_reg[dmic_pkg::MODE_DLL_BIT];
    end
    if (cmd_s2_reg == dmic_pkg::DMIC_REFRESH) begin
      // the row comes from the bank's own counter, not the address pins
      ref_en        = 1'b1;
      ref_bank_next = bank_s2_reg;
      ref_row_next  = row_reg[bank_s2_reg];
    end
    case (state_reg)
      DEV_IDLE: begin
        if (cmd_s2_reg == dmic_pkg::DMIC_READ || cmd_s2_reg == dmic_pkg::DMIC_WRITE) begin
          bank_next  = bank_s2_reg;
          col_next   = addr_s2_reg;
          left_next  = beats_reg[3:1];
          wait_next  = (cmd_s2_reg == dmic_pkg::DMIC_READ) ? RD_WAIT : WR_WAIT;
          state_next = (cmd_s2_reg == dmic_pkg::DMIC_READ) ? DEV_RD : DEV_WR;
        end
      end
      DEV_WR: begin
        if (wait_reg != 3'h0) begin
          wait_next = wait_reg - 3'h1;
        end else begin
          mem_we    = 1'b1;
          col_next  = col_reg + ADDR_W'(2);
          left_next = left_reg - 3'h1;
          if (left_reg == 3'h1) begin
            state_next = DEV_IDLE;
          end
        end
      end
      DEV_RD: begin
        if (wait_reg != 3'h0) begin
          wait_next = wait_reg - 3'h1;
        end else begin
          rd_rise_next  = mem_reg[idx0];
          rd_fall_next  = mem_reg[idx1];
          rd_valid_next = 1'b1;
          col_next      = col_reg + ADDR_W'(2);
          left_next     = left_reg - 3'h1;
          if (left_reg == 3'h1) begin
            state_next = DEV_IDLE;
          end
        end
      end
      default: begin
        state_next = DEV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg    <= DEV_IDLE;
      wait_reg     <= 3'h0;
      left_reg     <= 3'h0;
      bank_reg     <= '0;
      col_reg      <= '0;
      beats_reg    <= dmic_pkg::BEATS_RST;
      dll_reg      <= dmic_pkg::DLL_RST;
      rd_rise_reg  <= '0;
      rd_fall_reg  <= '0;
      rd_valid_reg <= 1'b0;
      ref_bank_reg <= '0;
      ref_row_reg  <= '0;
    end else begin
      state_reg    <= state_next;
      wait_reg     <= wait_next;
      left_reg     <= left_next;
      bank_reg     <= bank_next;
      col_reg      <= col_next;
      beats_reg    <= beats_next;
      dll_reg      <= dll_next;
      rd_rise_reg  <= rd_rise_next;
      rd_fall_reg  <= rd_fall_next;
      rd_valid_reg <= rd_valid_next;
      ref_bank_reg <= ref_bank_next;
      ref_row_reg  <= ref_row_next;
    end
  end

  // array contents are not reset; a read before any write returns unknowns
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem_reg[idx0] <= wpair_s2_reg[DQ_W-1:0];
      mem_reg[idx1] <= wpair_s2_reg[2*DQ_W-1:DQ_W];
    end
  end

  for (genvar b = 0; b < BANKS; b++) begin : g_bank
    logic [ROW_W-1:0] row_next;
    always_comb begin
      row_next = row_reg[b];
      if (ref_en && bank_s2_reg == BANK_W'(b)) begin
        row_next = row_reg[b] + ROW_W'(1);
      end
    end
    always_ff @(posedge clk) begin
      if (rst) begin
        row_reg[b] <= '0;
      end else begin
        row_reg[b] <= row_next;
      end
    end
  end

  // read strobes are forwarded copies of the command clock
  assign link.read_data_strobe   = {dmic_pkg::STROBES{clk}};
  assign link.read_data_strobe_n = ~{dmic_pkg::STROBES{clk}};

  // each nine-line group follows pair 0 or 1; pairs 2 and 3 duplicate them
  for (genvar g = 0; g < dmic_pkg::STROBES; g++) begin : g_group
    assign link.dev_dq[g*GRP_W +: GRP_W] = link.read_data_strobe[g % 2] ?
                                          rd_rise_reg[g*GRP_W +: GRP_W] :
                                          rd_fall_reg[g*GRP_W +: GRP_W];
  end

  assign link.dev_dq_oe  = rd_valid_reg;
  assign link.read_valid = rd_valid_reg;
  assign burst_beats_out  = beats_reg;
  assign dll_on_out       = dll_reg;
  assign refresh_bank_out = ref_bank_reg;
  assign refresh_row_out  = ref_row_reg;
endmodule

// ### core/dmic_host.sv
/*
  host controller end: makes the link clock by halving clk_in, issues one
  request at a time, streams write beats, collects read beats.
  assumes the device end sits on the other side of dmic_link_if.
*/
`timescale 1ns/100ps
module dmic_host #(
  parameter int ADDR_W = dmic_pkg::ADDR_W
) (
  input  wire logic                                        clk_in,
  input  wire logic                                        rst_in,
  dmic_link_if.host                                        link,
  input  wire logic                                        req_valid_in,
  output logic                                             req_ready_out,
  input  wire dmic_pkg::dmic_cmd_t                         req_cmd_in,
  input  wire logic [dmic_pkg::BANK_W-1:0]                 req_bank_in,
  input  wire logic [ADDR_W-1:0]                           req_addr_in,
  input  wire logic [dmic_pkg::MAX_BEATS*dmic_pkg::DQ_W-1:0] req_wdata_in,
  output logic [dmic_pkg::MAX_BEATS*dmic_pkg::DQ_W-1:0]      rdata_out,
  output logic                                             rdata_valid_out
);
  localparam int DQ_W = dmic_pkg::DQ_W;
  localparam int WD_W = dmic_pkg::MAX_BEATS * DQ_W;

  typedef enum logic [1:0] {
    HST_IDLE = 2'h0,
    HST_WR   = 2'h1,
    HST_RD   = 2'h2
  } dmic_hst_state_t;

  logic                          lclk_reg;
  dmic_hst_state_t               state_reg;
  dmic_hst_state_t               state_next;
  logic [5:0]                    ph_reg;
  logic [5:0]                    ph_next;
  logic [5:0]                    bidx;
  dmic_pkg::dmic_cmd_t           cmd_reg;
  dmic_pkg::dmic_cmd_t           cmd_next;
  logic [dmic_pkg::BANK_W-1:0]   bank_reg;
  logic [dmic_pkg::BANK_W-1:0]   bank_next;
  logic [ADDR_W-1:0]             addr_reg;
  logic [ADDR_W-1:0]             addr_next;
  logic [3:0]                    beats_reg;
  logic [3:0]                    beats_next;
  logic [WD_W-1:0]               wdata_reg;
  logic [WD_W-1:0]               wdata_next;
  logic [DQ_W-1:0]               wq_reg;
  logic [DQ_W-1:0]               wq_next;
  logic                          wq_oe_reg;
  logic                          wq_oe_next;
  logic [3:0]                    rcnt_reg;
  logic [3:0]                    rcnt_next;
  logic [WD_W-1:0]               rdata_reg;
  logic [WD_W-1:0]               rdata_next;
  logic                          rvalid_reg;
  logic                          rvalid_next;
  logic [DQ_W-1:0]               dq_reg;
  logic                          dq_oe_reg;
  logic [DQ_W-1:0]               cap_dq_reg;
  logic [1:0]                    cap_qk_reg;
  logic                          cap_vld_reg;
  logic [DQ_W-1:0]               dq_s2_reg;
  logic [1:0]                    qk_s2_reg;
  logic                          vld_s2_reg;
  logic                          take;

  // a request is taken only just before the link clock falls, so the command
  // stands half a link period before the device's rising edge
  assign req_ready_out = (state_reg == HST_IDLE) && lclk_reg;
  assign take          = req_valid_in && req_ready_out;
  assign bidx          = ph_reg - 6'h02;

  always_comb begin
    state_next  = state_reg;
    ph_next     = ph_reg;
    cmd_next    = cmd_reg;
    bank_next   = bank_reg;
    addr_next   = addr_reg;
    beats_next  = beats_reg;
    wdata_next  = wdata_reg;
    wq_next     = wq_reg;
    wq_oe_next  = 1'b0;
    rcnt_next   = rcnt_reg;
    rdata_next  = rdata_reg;
    rvalid_next = 1'b0;
    if (lclk_reg) begin
      cmd_next = dmic_pkg::DMIC_NOP;
    end
    if (take) begin
      bank_next  = req_bank_in;
      addr_next  = req_addr_in;
      wdata_next = req_wdata_in;
      ph_next    = 6'h01;
      rcnt_next  = 4'h0;
      case (req_cmd_in)
        dmic_pkg::DMIC_READ: begin
          cmd_next   = dmic_pkg::DMIC_READ;
          state_next = HST_RD;
        end
        dmic_pkg::DMIC_WRITE: begin
          cmd_next   = dmic_pkg::DMIC_WRITE;
          state_next = HST_WR;
        end
        dmic_pkg::DMIC_REFRESH: begin
          cmd_next  = dmic_pkg::DMIC_REFRESH;
          addr_next = '0;
        end
        dmic_pkg::DMIC_MODE: begin
          cmd_next = dmic_pkg::DMIC_MODE;
          addr_next[dmic_pkg::MODE_DLL_BIT] = 1'b1;
          case (req_addr_in[dmic_pkg::MODE_BL_LSB +: 2])
            dmic_pkg::BL_CODE_2: beats_next = dmic_pkg::BEATS_2;
            dmic_pkg::BL_CODE_4: beats_next = dmic_pkg::BEATS_4;
            dmic_pkg::BL_CODE_8: beats_next = dmic_pkg::BEATS_8;
            default:             beats_next = beats_reg;
          endcase
        end
        default: begin
          cmd_next = dmic_pkg::DMIC_NOP;
        end
      endcase
    end else if (state_reg == HST_WR) begin
      ph_next = ph_reg + 6'h01;
      if (ph_reg >= 6'h02 && ph_reg < {2'h0, beats_reg} + 6'h02) begin
        wq_next    = wdata_reg[bidx*DQ_W +: DQ_W];
        wq_oe_next = 1'b1;
      end
      if (ph_reg == {2'h0, beats_reg} + 6'(dmic_pkg::HOST_GAP)) begin
        state_next = HST_IDLE;
      end
    end else if (state_reg == HST_RD) begin
      ph_next = ph_reg + 6'h01;
      // a burst must open on the rising phase of both used strobe pairs
      if (vld_s2_reg && (rcnt_reg != 4'h0 || qk_s2_reg == 2'h3)) begin
        rdata_next[rcnt_reg*DQ_W +: DQ_W] = dq_s2_reg;
        rcnt_next = rcnt_reg + 4'h1;
        if (rcnt_reg + 4'h1 == beats_reg) begin
          rvalid_next = 1'b1;
          state_next  = HST_IDLE;
        end
      end
      if (ph_reg == 6'(dmic_pkg::RD_TIMEOUT)) begin
        state_next = HST_IDLE;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      lclk_reg   <= 1'b0;
      state_reg  <= HST_IDLE;
      ph_reg     <= 6'h00;
      cmd_reg    <= dmic_pkg::DMIC_NOP;
      bank_reg   <= '0;
      addr_reg   <= '0;
      beats_reg  <= dmic_pkg::BEATS_RST;
      wdata_reg  <= '0;
      wq_reg     <= '0;
      wq_oe_reg  <= 1'b0;
      rcnt_reg   <= 4'h0;
      rdata_reg  <= '0;
      rvalid_reg <= 1'b0;
    end else begin
      lclk_reg   <= ~lclk_reg;
      state_reg  <= state_next;
      ph_reg     <= ph_next;
      cmd_reg    <= cmd_next;
      bank_reg   <= bank_next;
      addr_reg   <= addr_next;
      beats_reg  <= beats_next;
      wdata_reg  <= wdata_next;
      wq_reg     <= wq_next;
      wq_oe_reg  <= wq_oe_next;
      rcnt_reg   <= rcnt_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // launching on the falling clk_in edge centres each beat on a strobe edge
  always_ff @(negedge clk_in) begin
    if (rst_in) begin
      dq_reg    <= '0;
      dq_oe_reg <= 1'b0;
    end else begin
      dq_reg    <= wq_reg;
      dq_oe_reg <= wq_oe_reg;
    end
  end

  // read halves are sampled mid-beat, then re-timed before any logic sees them
  always_ff @(negedge clk_in) begin
    cap_dq_reg  <= link.dq;
    cap_qk_reg  <= link.read_data_strobe[1:0];
    cap_vld_reg <= link.read_valid;
  end

  always_ff @(posedge clk_in) begin
    dq_s2_reg  <= cap_dq_reg;
    qk_s2_reg  <= cap_qk_reg;
    vld_s2_reg <= cap_vld_reg;
  end

  assign link.command_clock     = lclk_reg;
  assign link.write_data_strobe = lclk_reg;
  assign link.cmd               = cmd_reg;
  assign link.bank              = bank_reg;
  assign link.addr              = addr_reg;
  assign link.host_dq           = dq_reg;
  assign link.host_dq_oe        = dq_oe_reg;
  assign rdata_out              = rdata_reg;
  assign rdata_valid_out        = rvalid_reg;
endmodule

// ### verification/dmic_link_props.sv
/*
  assertions on the link between host and device ends.
  assumes clk_in makes the link clock; rst_in is the later device reset.
*/
`timescale 1ns/100ps
module dmic_link_props (
  input wire logic                          clk_in,
  input wire logic                          rst_in,
  input wire logic                          command_clock,
  input wire logic                          write_data_strobe,
  input wire dmic_pkg::dmic_cmd_t           cmd,
  input wire logic                          host_dq_oe,
  input wire logic                          dev_dq_oe,
  input wire logic [dmic_pkg::STROBES-1:0]  read_data_strobe,
  input wire logic [dmic_pkg::STROBES-1:0]  read_data_strobe_n,
  input wire logic                          read_valid
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence rd_cmd;
    $rose(command_clock) && cmd == dmic_pkg::DMIC_READ;
  endsequence
  sequence wr_cmd;
    $rose(command_clock) && cmd == dmic_pkg::DMIC_WRITE;
  endsequence
  // the link clock already runs when this later reset ends; the first edge after it is skipped
  AST_LINK_TOGGLE: assert property (!$past(rst_in) |-> command_clock != $past(command_clock))
    else $error("link clock not halving clk_in");
  AST_WSTROBE: assert property (write_data_strobe == command_clock)
    else $error("write strobe not following link clock");
  AST_CMD_HOLD: assert property ($changed(cmd) |-> $fell(command_clock))
    else $error("command moved away from falling link edge");
  AST_ONE_DRIVER: assert property (!(dev_dq_oe && host_dq_oe))
    else $error("both ends drive data");
  AST_QK_N: assert property (read_data_strobe_n == ~read_data_strobe)
    else $error("read strobe pair not complementary");
  AST_QK_DUP: assert property (read_data_strobe[3:2] == read_data_strobe[1:0])
    else $error("strobe pairs 2 3 differ from 0 1");
  AST_QK_FOUR: assert property (read_data_strobe == {dmic_pkg::STROBES{command_clock}})
    else $error("read strobe pairs not all following link clock");
  // codes above the last defined one must never reach the link
  AST_CMD_DEFINED: assert property (cmd <= dmic_pkg::DMIC_MODE)
    else $error("undefined command driven on link");
  AST_RD_LAT: assert property (rd_cmd |-> ##[7:9] $rose(read_valid))
    else $error("read data late or missing");
  AST_RD_LEN: assert property ($rose(read_valid) |-> read_valid [*2] ##[1:7] !read_valid)
    else $error("read burst length out of range");
  AST_RD_OE: assert property (read_valid |-> dev_dq_oe)
    else $error("read data valid without drive");
  AST_WR_OE: assert property (wr_cmd |-> ##[1:2] $rose(host_dq_oe))
    else $error("write data not driven after command");
endmodule

// ### verification/ddr_memory_io_capture_tb.sv
/*
  bench joining host and device ends: random bursts per length, bank
  separation, refresh rows. assumes package and interface compiled first.
*/
`timescale 1ns/100ps
module ddr_memory_io_capture_tb;
  logic                clk_in = 1'h0;
  logic                rst_in = 1'h1;
  logic                rst_dev = 1'h1;
  logic                req_valid_in = 1'h0;
  logic                req_ready_out;
  dmic_pkg::dmic_cmd_t req_cmd_in = dmic_pkg::DMIC_NOP;
  logic [3:0]          req_bank_in = 4'h0;
  logic [3:0]          req_addr_in = 4'h0;
  logic [287:0]        req_wdata_in = '0;
  logic [287:0]        rdata_out;
  logic                rdata_valid_out;
  logic [3:0]          burst_beats_out;
  logic                dll_on_out;
  logic [3:0]          refresh_bank_out;
  logic [7:0]          refresh_row_out;
  logic [7:0]          r;
  logic [3:0]          b;
  logic [3:0]          a;
  logic [287:0]        d0;
  logic [287:0]        d1;
  logic [287:0]        q;
  int                  n_errors = 0;
  int                  samples_checked = 0;
  int                  cyc = 0;
  int                  bl;
  int                  seed = 32'h538627d1;

  dmic_link_if lk ();
  dmic_host dmic_host_i (.clk_in(clk_in), .rst_in(rst_in), .link(lk), .req_valid_in(req_valid_in),
    .req_ready_out(req_ready_out), .req_cmd_in(req_cmd_in), .req_bank_in(req_bank_in),
    .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in), .rdata_out(rdata_out),
    .rdata_valid_out(rdata_valid_out));
  dmic_device dmic_device_i (.link(lk), .rst_in(rst_dev), .burst_beats_out(burst_beats_out),
    .dll_on_out(dll_on_out), .refresh_bank_out(refresh_bank_out), .refresh_row_out(refresh_row_out));
  dmic_link_props dmic_link_props_i (.clk_in(clk_in), .rst_in(rst_dev), .command_clock(lk.command_clock),
    .write_data_strobe(lk.write_data_strobe), .cmd(lk.cmd), .host_dq_oe(lk.host_dq_oe),
    .dev_dq_oe(lk.dev_dq_oe), .read_data_strobe(lk.read_data_strobe),
    .read_data_strobe_n(lk.read_data_strobe_n), .read_valid(lk.read_valid));

  always #2.5 clk_in = ~clk_in;

  task automatic end_sim();
    if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // a hung handshake ends here instead of running forever
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [287:0] got, input logic [287:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask

  // an edge always passes before valid rises again
  task automatic req(input dmic_pkg::dmic_cmd_t c, input logic [3:0] bk, input logic [3:0] ad,
                     input logic [287:0] w);
    @(posedge clk_in);
    #1;
    req_cmd_in = c;
    req_bank_in = bk;
    req_addr_in = ad;
    req_wdata_in = w;
    req_valid_in = 1'h1;
    while (req_ready_out !== 1'h1) begin
      @(posedge clk_in);
      #1;
    end
    @(posedge clk_in);
    #1;
    req_valid_in = 1'h0;
  endtask

  task automatic rd(input logic [3:0] bk, input logic [3:0] ad, output logic [287:0] d);
    int n = 0;
    req(dmic_pkg::DMIC_READ, bk, ad, '0);
    while (rdata_valid_out !== 1'h1 && n < 100) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    d = rdata_out;
  endtask

  function automatic logic [287:0] rnd();
    logic [287:0] v;
    for (int i = 0; i < 9; i++) v[i*32+:32] = $random(seed);
    return v;
  endfunction

  // only the first bl beats of a burst carry data
  function automatic logic [287:0] vis(input logic [287:0] d, input int n);
    return d & ((288'h1 << (n * 36)) - 288'h1);
  endfunction

  initial begin
    repeat (8) @(posedge clk_in);
    #1;
    rst_in = 1'h0;
    repeat (10) @(posedge clk_in);
    #1;
    rst_dev = 1'h0;
    repeat (12) @(posedge clk_in);
    #1;
    chk("beats_rst", 288'(burst_beats_out), 288'(dmic_pkg::BEATS_RST));
    chk("dll_rst", 288'(dll_on_out), 288'(dmic_pkg::DLL_RST));
    for (int k = 0; k < 3; k++) begin
      bl = 2 << k;
      req(dmic_pkg::DMIC_MODE, 4'h0, 4'(k), '0);
      repeat (10) @(posedge clk_in);
      #1;
      chk("beats", 288'(burst_beats_out), 288'(bl));
      chk("dll", 288'(dll_on_out), 288'h1);
      b = 4'($random(seed));
      a = (k == 2) ? 4'hf : 4'($random(seed));
      d0 = rnd();
      d1 = rnd();
      req(dmic_pkg::DMIC_WRITE, b, a, d0);
      req(dmic_pkg::DMIC_WRITE, b ^ 4'h1, a, d1);
      rd(b, a, q);
      chk("rd_first", vis(q, bl), vis(d0, bl));
      rd(b ^ 4'h1, a, q);
      chk("rd_other", vis(q, bl), vis(d1, bl));
    end
    // an undefined code must go out as a no-op and leave the burst setting alone
    req(dmic_pkg::dmic_cmd_t'(3'h5), 4'h0, 4'h0, '0);
    repeat (10) @(posedge clk_in);
    #1;
    chk("undef_beats", 288'(burst_beats_out), 288'(dmic_pkg::BEATS_8));
    b = 4'($random(seed));
    req(dmic_pkg::DMIC_REFRESH, b, 4'h0, '0);
    repeat (10) @(posedge clk_in);
    #1;
    r = refresh_row_out;
    req(dmic_pkg::DMIC_REFRESH, b ^ 4'h1, 4'h0, '0);
    req(dmic_pkg::DMIC_REFRESH, b, 4'h0, '0);
    repeat (10) @(posedge clk_in);
    #1;
    chk("ref_bank", 288'(refresh_bank_out), 288'(b));
    chk("ref_row", 288'(refresh_row_out), 288'(r + 8'h1));
    end_sim();
  end
endmodule
